/* hdl/scmc_top.sv */
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ps
module scmc_top
   import scmc_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // register bus
   input wire scmc_axi_req_s axi_req,
   output scmc_axi_rsp_s axi_rsp,
   // cpu side, same clock domain
   input wire logic halt_req,
   input wire logic wake_req,
   input wire logic wdt_enable,
   // clock ticks out
   output logic core_clk_tick,
   output logic [NUM_DIV-1:0] periph_fast_ticks,
   output logic sub_clk_tick,
   output logic wdt_clk_tick,
   // state out
   output logic cpu_run,
   output scmc_mode_e op_mode,
   output logic fast_osc_on,
   output logic slow_osc_on,
   output logic irq
);

   function automatic logic [ACC_W:0] osc_step(input logic [ACC_W-1:0] acc,
                                               input logic [ACC_W-1:0] step);
      logic [ACC_W:0] sum;
      logic [ACC_W:0] wrap;
      sum = {1'b0, acc} + {1'b0, step};
      wrap = sum - {1'b0, ACC_DEN};
      if (sum >= {1'b0, ACC_DEN}) begin
         return {1'b1, wrap[ACC_W-1:0]};
      end
      return {1'b0, sum[ACC_W-1:0]};
   endfunction

   // true when the low sel bits of the divider are all ones
   function automatic logic div_hit(input logic [DIV_W-1:0] cnt, input logic [2:0] sel);
      logic [DIV_W-1:0] mask;
      mask = ~(6'h3F << sel);
      return &(cnt | ~mask);
   endfunction

   function automatic scmc_mode_e halt_mode(input logic fidle, input logic sidle);
      unique case ({fidle, sidle})
         2'b00: return SCMC_SLEEP;
         2'b01: return SCMC_IDLE_SUB_ONLY;
         2'b11: return SCMC_IDLE_BOTH_ON;
         2'b10: return SCMC_IDLE_FAST_ONLY;
      endcase
   endfunction

   function automatic logic core_runs(input scmc_mode_e mode, input logic [2:0] sel);
      unique case (mode)
         SCMC_NORMAL, SCMC_SLOW, SCMC_IDLE_BOTH_ON: return 1'b1;
         SCMC_SLEEP: return 1'b0;
         SCMC_IDLE_SUB_ONLY: return sel == SEL_SUB;
         SCMC_IDLE_FAST_ONLY: return sel != SEL_SUB;
         default: return 1'b0;
      endcase
   endfunction

   function automatic logic [7:0] word_addr(input logic [7:0] a);
      return {a[7:2], 2'b00};
   endfunction

   // control registers
   logic [2:0] cks_ff;
   logic fidle_ff;
   logic sidle_ff;
   logic fast_en_ff;
   logic [2:0] eff_sel_ff;
   logic halted_ff;
   scmc_mode_e halt_mode_ff;
   // oscillator models
   logic [ACC_W-1:0] fast_acc_ff;
   logic [ACC_W-1:0] slow_acc_ff;
   logic [DIV_W-1:0] fast_div_cnt_ff;
   logic [STAB_W-1:0] fast_cnt_ff;
   logic [STAB_W-1:0] slow_cnt_ff;
   logic fast_stable_ff;
   logic slow_stable_ff;
   // interrupt
   logic [IRQ_W-1:0] irq_status_ff;
   logic [IRQ_W-1:0] irq_mask_ff;
   // bus slave
   logic awready_ff;
   logic wready_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic arready_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   logic aw_full_ff;
   logic w_full_ff;
   logic [7:0] waddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   // outputs
   logic core_clk_tick_ff;
   logic [NUM_DIV-1:0] periph_ticks_ff;
   logic sub_clk_tick_ff;
   logic wdt_clk_tick_ff;
   logic cpu_run_ff;
   scmc_mode_e op_mode_ff;
   logic fast_osc_on_ff;
   logic slow_osc_on_ff;
   logic irq_ff;

   // operating mode
   scmc_mode_e mode_w;
   assign mode_w = halted_ff ? halt_mode_ff :
                   (eff_sel_ff == SEL_SUB ? SCMC_SLOW : SCMC_NORMAL);

   // fast osc: in halt by its idle bit, otherwise on unless core sits on sub,
   // sub is still the selected clock and the enable bit is low
   logic fast_on_w;
   assign fast_on_w = halted_ff ?
      (halt_mode_ff == SCMC_IDLE_BOTH_ON || halt_mode_ff == SCMC_IDLE_FAST_ONLY) :
      (eff_sel_ff != SEL_SUB || cks_ff != SEL_SUB || fast_en_ff);

   // slow osc survives sleep only for the watchdog
   logic slow_on_w;
   logic sub_on_w;
   assign slow_on_w = !(mode_w == SCMC_SLEEP && !wdt_enable);
   assign sub_on_w = slow_on_w && mode_w != SCMC_SLEEP && mode_w != SCMC_IDLE_FAST_ONLY;

   // oscillator tick models
   logic [ACC_W:0] fast_step_w;
   logic [ACC_W:0] slow_step_w;
   logic fast_tick_w;
   logic slow_tick_w;
   logic sub_tick_w;
   assign fast_step_w = osc_step(fast_acc_ff, FAST_STEP);
   assign slow_step_w = osc_step(slow_acc_ff, SLOW_STEP);
   assign fast_tick_w = fast_on_w && fast_step_w[ACC_W];
   assign slow_tick_w = slow_on_w && slow_step_w[ACC_W];
   assign sub_tick_w = sub_on_w && slow_tick_w;

   // divided fast ticks for peripherals and the core
   logic [NUM_DIV-1:0] periph_div_w;
   for (genvar k = 0; k < NUM_DIV; k++) begin : g_div
      assign periph_div_w[k] = fast_tick_w && div_hit(fast_div_cnt_ff, 3'(k));
   end

   logic core_src_w;
   logic core_run_w;
   assign core_src_w = (eff_sel_ff == SEL_SUB) ? sub_tick_w : periph_div_w[eff_sel_ff];
   assign core_run_w = core_runs(mode_w, eff_sel_ff);

   // clock switch follows the request only once the target is stable
   logic [2:0] nxt_eff_sel;
   assign nxt_eff_sel = halted_ff ? eff_sel_ff :
      (cks_ff == SEL_SUB) ? (slow_stable_ff ? SEL_SUB : eff_sel_ff) :
      (fast_stable_ff ? cks_ff : eff_sel_ff);

   // stabilisation counters restart whenever an oscillator stops
   logic [STAB_W-1:0] nxt_fast_cnt;
   logic [STAB_W-1:0] nxt_slow_cnt;
   assign nxt_fast_cnt = !fast_on_w ? '0 :
      (fast_cnt_ff == FAST_STAB_CYC ? fast_cnt_ff : fast_cnt_ff + 12'h001);
   assign nxt_slow_cnt = !slow_on_w ? '0 :
      (slow_cnt_ff == SLOW_STAB_CYC ? slow_cnt_ff : slow_cnt_ff + 12'h001);

   // bus slave decode
   logic aw_hs_w;
   logic w_hs_w;
   logic ar_hs_w;
   logic wr_fire_w;
   logic [7:0] wa_w;
   logic [7:0] ra_w;
   logic wr_lane_w;
   assign aw_hs_w = axi_req.awvalid && awready_ff;
   assign w_hs_w = axi_req.wvalid && wready_ff;
   assign ar_hs_w = axi_req.arvalid && arready_ff;
   assign wr_fire_w = aw_full_ff && w_full_ff && !bvalid_ff;
   assign wa_w = word_addr(waddr_ff);
   assign ra_w = word_addr(axi_req.araddr);
   assign wr_lane_w = wr_fire_w && wstrb_ff[0];

   logic wr_hit_w;
   logic wr_scc_w;
   logic wr_foc_w;
   logic wr_ist_w;
   logic wr_imask_w;
   assign wr_scc_w = wr_lane_w && wa_w == ADDR_SCC;
   assign wr_foc_w = wr_lane_w && wa_w == ADDR_FOC;
   assign wr_ist_w = wr_lane_w && wa_w == ADDR_IRQ_STATUS;
   assign wr_imask_w = wr_lane_w && wa_w == ADDR_IRQ_MASK;
   assign wr_hit_w = wa_w == ADDR_SCC || wa_w == ADDR_FOC || wa_w == ADDR_IRQ_STATUS ||
                     wa_w == ADDR_IRQ_MASK || wa_w == ADDR_MODE_STATUS;

   logic nxt_aw_full;
   logic nxt_w_full;
   logic nxt_rvalid;
   assign nxt_aw_full = (aw_full_ff || aw_hs_w) && !wr_fire_w;
   assign nxt_w_full = (w_full_ff || w_hs_w) && !wr_fire_w;
   assign nxt_rvalid = ar_hs_w || (rvalid_ff && !axi_req.rready);

   // read views
   scmc_mode_status_s mstat_w;
   assign mstat_w = '{switch_pending: eff_sel_ff != cks_ff, slow_on: slow_on_w,
                      sub_on: sub_on_w, fast_on: fast_on_w, core_on: core_run_w,
                      mode: mode_w};
   logic [7:0] scc_rd_w;
   logic [7:0] foc_rd_w;
   logic [7:0] rd_byte_w;
   logic rd_hit_w;
   assign scc_rd_w = {cks_ff, 3'b000, fidle_ff, sidle_ff};
   assign foc_rd_w = {6'h00, fast_stable_ff, fast_en_ff};
   assign rd_hit_w = ra_w == ADDR_SCC || ra_w == ADDR_FOC || ra_w == ADDR_IRQ_STATUS ||
                     ra_w == ADDR_IRQ_MASK || ra_w == ADDR_MODE_STATUS;
   assign rd_byte_w = (ra_w == ADDR_SCC) ? scc_rd_w :
                      (ra_w == ADDR_FOC) ? foc_rd_w :
                      (ra_w == ADDR_IRQ_STATUS) ? {5'h00, irq_status_ff} :
                      (ra_w == ADDR_IRQ_MASK) ? {5'h00, irq_mask_ff} :
                      (ra_w == ADDR_MODE_STATUS) ? mstat_w : 8'h00;

   // interrupt events; a new event wins over a write-one clear
   logic [IRQ_W-1:0] ev_w;
   logic [IRQ_W-1:0] nxt_irq_status;
   assign ev_w[IRQ_FAST_STABLE] = !fast_stable_ff && fast_on_w && nxt_fast_cnt == FAST_STAB_CYC;
   assign ev_w[IRQ_SLOW_STABLE] = !slow_stable_ff && slow_on_w && nxt_slow_cnt == SLOW_STAB_CYC;
   assign ev_w[IRQ_SWITCH_DONE] = nxt_eff_sel != eff_sel_ff;
   assign nxt_irq_status = (irq_status_ff & ~(wr_ist_w ? wdata_ff[IRQ_W-1:0] : 3'h0)) | ev_w;

   // control registers
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cks_ff <= SCC_RST[SCC_SEL_LSB +: 3];
         fidle_ff <= SCC_RST[SCC_FIDLE_BIT];
         sidle_ff <= SCC_RST[SCC_SIDLE_BIT];
         fast_en_ff <= FOC_RST[FOC_EN_BIT];
         irq_mask_ff <= IRQ_RST;
      end else begin
         if (wr_scc_w) begin
            cks_ff <= wdata_ff[SCC_SEL_LSB +: 3];
            fidle_ff <= wdata_ff[SCC_FIDLE_BIT];
            sidle_ff <= wdata_ff[SCC_SIDLE_BIT];
         end
         if (wr_foc_w) begin
            fast_en_ff <= wdata_ff[FOC_EN_BIT];
         end
         if (wr_imask_w) begin
            irq_mask_ff <= wdata_ff[IRQ_W-1:0];
         end
      end
   end

   // halt and wake; halt mode latched from the idle bits
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         halted_ff <= 1'b0;
         halt_mode_ff <= SCMC_SLEEP;
      end else if (!halted_ff && halt_req) begin
         halted_ff <= 1'b1;
         halt_mode_ff <= halt_mode(fidle_ff, sidle_ff);
      end else if (halted_ff && wake_req) begin
         halted_ff <= 1'b0;
      end
   end

   // oscillators, divider, stability
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         eff_sel_ff <= SCC_RST[SCC_SEL_LSB +: 3];
         fast_acc_ff <= '0;
         slow_acc_ff <= '0;
         fast_div_cnt_ff <= '0;
         fast_cnt_ff <= '0;
         slow_cnt_ff <= '0;
         fast_stable_ff <= 1'b0;
         slow_stable_ff <= 1'b0;
         irq_status_ff <= IRQ_RST;
      end else begin
         eff_sel_ff <= nxt_eff_sel;
         fast_acc_ff <= fast_on_w ? fast_step_w[ACC_W-1:0] : '0;
         slow_acc_ff <= slow_on_w ? slow_step_w[ACC_W-1:0] : '0;
         fast_div_cnt_ff <= !fast_on_w ? '0 :
                            (fast_tick_w ? fast_div_cnt_ff + 6'h01 : fast_div_cnt_ff);
         fast_cnt_ff <= nxt_fast_cnt;
         slow_cnt_ff <= nxt_slow_cnt;
         fast_stable_ff <= fast_on_w && nxt_fast_cnt == FAST_STAB_CYC;
         slow_stable_ff <= slow_on_w && nxt_slow_cnt == SLOW_STAB_CYC;
         irq_status_ff <= nxt_irq_status;
      end
   end

   // registered outputs; watchdog takes the raw slow osc
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         core_clk_tick_ff <= 1'b0;
         periph_ticks_ff <= '0;
         sub_clk_tick_ff <= 1'b0;
         wdt_clk_tick_ff <= 1'b0;
         cpu_run_ff <= 1'b0;
         op_mode_ff <= SCMC_NORMAL;
         fast_osc_on_ff <= 1'b0;
         slow_osc_on_ff <= 1'b0;
         irq_ff <= 1'b0;
      end else begin
         core_clk_tick_ff <= core_run_w && core_src_w;
         periph_ticks_ff <= periph_div_w;
         sub_clk_tick_ff <= sub_tick_w;
         wdt_clk_tick_ff <= slow_tick_w;
         cpu_run_ff <= !halted_ff;
         op_mode_ff <= mode_w;
         fast_osc_on_ff <= fast_on_w;
         slow_osc_on_ff <= slow_on_w;
         irq_ff <= |(irq_status_ff & irq_mask_ff);
      end
   end

   // bus slave: one write and one read in flight
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         aw_full_ff <= 1'b0;
         w_full_ff <= 1'b0;
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
         waddr_ff <= 8'h00;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
      end else begin
         aw_full_ff <= nxt_aw_full;
         w_full_ff <= nxt_w_full;
         awready_ff <= !nxt_aw_full;
         wready_ff <= !nxt_w_full;
         if (aw_hs_w) begin
            waddr_ff <= axi_req.awaddr;
         end
         if (w_hs_w) begin
            wdata_ff <= axi_req.wdata;
            wstrb_ff <= axi_req.wstrb;
         end
         if (wr_fire_w) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_hit_w ? RESP_OKAY : RESP_SLVERR;
         end else if (axi_req.bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= RESP_OKAY;
      end else begin
         arready_ff <= !nxt_rvalid;
         rvalid_ff <= nxt_rvalid;
         if (ar_hs_w) begin
            rdata_ff <= {24'h00_0000, rd_byte_w};
            rresp_ff <= rd_hit_w ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   assign axi_rsp = '{awready: awready_ff, wready: wready_ff, bvalid: bvalid_ff,
                      bresp: bresp_ff, arready: arready_ff, rvalid: rvalid_ff,
                      rdata: rdata_ff, rresp: rresp_ff};
   assign core_clk_tick = core_clk_tick_ff;
   assign periph_fast_ticks = periph_ticks_ff;
   assign sub_clk_tick = sub_clk_tick_ff;
   assign wdt_clk_tick = wdt_clk_tick_ff;
   assign cpu_run = cpu_run_ff;
   assign op_mode = op_mode_ff;
   assign fast_osc_on = fast_osc_on_ff;
   assign slow_osc_on = slow_osc_on_ff;
   assign irq = irq_ff;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   a_sub_core_src: assert property (
      core_clk_tick_ff && $past(eff_sel_ff) == SEL_SUB |-> $past(slow_tick_w))
      else $error("core tick on sub select without slow tick");
   a_div64_core: assert property (
      core_clk_tick_ff && $past(eff_sel_ff) == 3'h6 |-> $past(fast_div_cnt_ff) == 6'h3F)
      else $error("divide by 64 core tick off phase");
   a_fast_rate: assert property (
      fast_tick_w |=> !fast_tick_w ##1 !fast_tick_w)
      else $error("fast oscillator ticks too close");
   a_slow_rate: assert property (
      wdt_clk_tick_ff |=> !wdt_clk_tick_ff [*8])
      else $error("slow oscillator ticks too close");
   a_slow_fast_en: assert property (
      !halted_ff && eff_sel_ff == SEL_SUB && cks_ff == SEL_SUB && !fast_en_ff
      |=> !fast_osc_on_ff && !periph_fast_ticks[0])
      else $error("fast osc runs in slow mode while disabled");
   a_halt_stops_cpu: assert property (
      !halted_ff && halt_req |=> ##1 (!cpu_run_ff && op_mode_ff != SCMC_NORMAL))
      else $error("cpu still running after halt");
   a_sleep_sub_off: assert property (
      halted_ff && halt_mode_ff == SCMC_SLEEP |=> !sub_clk_tick_ff && !core_clk_tick_ff)
      else $error("sub or core clock runs in sleep");
   a_sleep_wdt: assert property (
      mode_w == SCMC_SLEEP |=> slow_osc_on_ff == $past(wdt_enable))
      else $error("slow osc not following watchdog in sleep");
   a_halt_decode: assert property (
      !halted_ff && halt_req && !fidle_ff && sidle_ff |=> halt_mode_ff == SCMC_IDLE_SUB_ONLY)
      else $error("idle_sub_only not entered");
   a_idle_fast_osc: assert property (
      !halted_ff && halt_req |=> fast_on_w == $past(fidle_ff) &&
                                 slow_on_w == ($past(fidle_ff || sidle_ff) || wdt_enable)
                                 ##1 fast_osc_on_ff == $past(fidle_ff, 2))
      else $error("fast osc does not follow idle bit");
   a_idle_sub_osc: assert property (
      halted_ff && halt_mode_ff inside {SCMC_IDLE_SUB_ONLY, SCMC_IDLE_BOTH_ON}
      |=> !halted_ff || sub_on_w)
      else $error("slow osc stopped though idle bit set");
   a_rsv_zero: assert property (
      ar_hs_w && ra_w == ADDR_SCC |=> rvalid_ff && rdata_ff[4:2] == 3'h0)
      else $error("reserved control bits read nonzero");
   a_idle_core: assert property (
      halted_ff && halt_mode_ff == SCMC_IDLE_FAST_ONLY && eff_sel_ff == SEL_SUB
      |=> !core_clk_tick_ff)
      else $error("core clock runs from a stopped oscillator");
   a_flag_wait: assert property (
      !fast_on_w ##1 fast_on_w |-> !fast_stable_ff [*2])
      else $error("fast stable flag set without settling");
   a_slow_switch: assert property (
      eff_sel_ff != SEL_SUB ##1 eff_sel_ff == SEL_SUB |-> $past(slow_stable_ff))
      else $error("switch to sub before slow osc stable");
   a_irq_level: assert property (
      ev_w != 3'h0 |=> irq_status_ff != 3'h0 ##1 irq == |($past(irq_status_ff & irq_mask_ff)))
      else $error("interrupt status or line wrong");

   c_idle_sub: cover property (halted_ff && halt_mode_ff == SCMC_IDLE_SUB_ONLY);
   c_idle_both: cover property (halted_ff && halt_mode_ff == SCMC_IDLE_BOTH_ON);
   c_slow_mode: cover property (op_mode_ff == SCMC_SLOW && !fast_osc_on_ff);
   c_fast_restab: cover property (!fast_stable_ff ##1 fast_stable_ff && eff_sel_ff == SEL_SUB);

endmodule // scmc_top

/* common/scmc_pkg.sv */
package scmc_pkg;

   // system clock and oscillator rates
   localparam int SYS_CLK_KHZ = 25000;
   localparam int SYS_CLK_PERIOD_NS = 40;
   localparam int FAST_OSC_KHZ = 8000;
   localparam int SLOW_OSC_KHZ = 32;

   // stabilisation times, least values, rounded up to whole cycles
   localparam int FAST_STAB_NS = 16000;
   localparam int SLOW_STAB_NS = 100000;
   localparam int STAB_W = 12;
   localparam logic [STAB_W-1:0] FAST_STAB_CYC =
      STAB_W'((FAST_STAB_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS);
   localparam logic [STAB_W-1:0] SLOW_STAB_CYC =
      STAB_W'((SLOW_STAB_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS);

   // phase accumulators that model the oscillators on sys_clk
   localparam int ACC_W = 15;
   localparam logic [ACC_W-1:0] ACC_DEN = ACC_W'(SYS_CLK_KHZ);
   localparam logic [ACC_W-1:0] FAST_STEP = ACC_W'(FAST_OSC_KHZ);
   localparam logic [ACC_W-1:0] SLOW_STEP = ACC_W'(SLOW_OSC_KHZ);
   localparam int DIV_W = 6;
   localparam int NUM_DIV = 7;

   // register byte addresses
   localparam logic [7:0] ADDR_SCC = 8'h00;
   localparam logic [7:0] ADDR_FOC = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
   localparam logic [7:0] ADDR_MODE_STATUS = 8'h10;

   // field positions and reset values
   localparam int SCC_SEL_LSB = 5;
   localparam int SCC_FIDLE_BIT = 1;
   localparam int SCC_SIDLE_BIT = 0;
   localparam int FOC_EN_BIT = 0;
   localparam int FOC_FLAG_BIT = 1;
   localparam logic [7:0] SCC_RST = 8'h00;
   localparam logic [7:0] FOC_RST = 8'h01;
   localparam logic [2:0] SEL_SUB = 3'h7;
   localparam int IRQ_W = 3;
   localparam int IRQ_FAST_STABLE = 0;
   localparam int IRQ_SLOW_STABLE = 1;
   localparam int IRQ_SWITCH_DONE = 2;
   localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      SCMC_NORMAL, SCMC_SLOW, SCMC_SLEEP,
      SCMC_IDLE_SUB_ONLY, SCMC_IDLE_BOTH_ON, SCMC_IDLE_FAST_ONLY
   } scmc_mode_e;

   typedef struct packed {
      logic switch_pending;
      logic slow_on;
      logic sub_on;
      logic fast_on;
      logic core_on;
      scmc_mode_e mode;
   } scmc_mode_status_s;

   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } scmc_axi_req_s;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } scmc_axi_rsp_s;

endpackage

/* dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top
   import scmc_pkg::*;
   ;
   logic sys_clk, reset, halt_req, wake_req, wdt_enable;
   scmc_axi_req_s axi_req;
   scmc_axi_rsp_s axi_rsp;
   logic core_clk_tick, cpu_run, fast_osc_on, slow_osc_on, irq;
   scmc_mode_e op_mode;
   logic [NUM_DIV-1:0] periph_fast_ticks;
   int mismatches = 0;
   int comparisons = 0;
   scmc_top u_scmc_top (.sys_clk(sys_clk), .reset(reset), .axi_req(axi_req), .axi_rsp(axi_rsp),
      .halt_req(halt_req), .wake_req(wake_req), .wdt_enable(wdt_enable),
      .core_clk_tick(core_clk_tick), .periph_fast_ticks(periph_fast_ticks), .sub_clk_tick(),
      .wdt_clk_tick(),
      .cpu_run(cpu_run), .op_mode(op_mode), .fast_osc_on(fast_osc_on),
      .slow_osc_on(slow_osc_on), .irq(irq));
   always #20 sys_clk = ~sys_clk;
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask
   // master holds each channel until its own ready; the bench timeout ends a hang
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      axi_req.awvalid <= 1'b1;
      axi_req.awaddr <= a;
      axi_req.wvalid <= 1'b1;
      axi_req.wdata <= {24'h00_0000, d};
      axi_req.wstrb <= 4'hf;
      axi_req.bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
         if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
      end while (axi_rsp.bvalid !== 1'b1);
      axi_req.bready <= 1'b0;
      chk("bresp", 32'h0000_0000, {30'h0, axi_rsp.bresp});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      axi_req.arvalid <= 1'b1;
      axi_req.araddr <= a;
      axi_req.rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
      end while (axi_rsp.rvalid !== 1'b1);
      axi_req.rready <= 1'b0;
      chk("rresp", {30'h0, er}, {30'h0, axi_rsp.rresp});
      if (er == RESP_OKAY) chk("rdata", e, axi_rsp.rdata);
   endtask
   task automatic t_regs();
      rd(ADDR_SCC, 32'h0000_0000, RESP_OKAY);
      rd(ADDR_FOC, 32'h0000_0001, RESP_OKAY);
      chk("op_mode", 32'(SCMC_NORMAL), 32'(op_mode));
      wr(ADDR_SCC, 8'h1f);
      rd(ADDR_SCC, 32'h0000_0003, RESP_OKAY);
      rd(8'h14, 32'h0000_0000, RESP_SLVERR);
   endtask
   task automatic t_irq();
      repeat (450) @(posedge sys_clk);
      rd(ADDR_FOC, 32'h0000_0003, RESP_OKAY);
      rd(ADDR_IRQ_STATUS, 32'h0000_0001, RESP_OKAY);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(ADDR_IRQ_MASK, 8'h01);
      repeat (3) @(posedge sys_clk);
      chk("irq raised", 32'h1, {31'h0, irq});
      wr(ADDR_IRQ_STATUS, 8'h01);
      repeat (3) @(posedge sys_clk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      rd(ADDR_IRQ_STATUS, 32'h0000_0000, RESP_OKAY);
   endtask
   // fast select 0: core clock runs in halt only if the fast osc is kept
   task automatic t_halt(input logic fi, input logic si, input logic wdt, input scmc_mode_e m);
      int n;
      int p;
      wdt_enable <= wdt;
      wr(ADDR_SCC, {6'h00, fi, si});
      halt_req <= 1'b1;
      @(posedge sys_clk);
      halt_req <= 1'b0;
      repeat (4) @(posedge sys_clk);
      chk("cpu_run halted", 32'h0, {31'h0, cpu_run});
      chk("op_mode", 32'(m), 32'(op_mode));
      chk("fast_osc_on", {31'h0, fi}, {31'h0, fast_osc_on});
      chk("slow_osc_on", {31'h0, fi | si | wdt}, {31'h0, slow_osc_on});
      n = 0;
      p = 0;
      repeat (30) begin
         @(posedge sys_clk);
         n += int'(core_clk_tick === 1'b1);
         p += int'(periph_fast_ticks[0] === 1'b1);
      end
      chk("core ticks", {31'h0, fi}, {31'h0, n != 0});
      chk("periph fast ticks", {31'h0, fi}, {31'h0, p != 0});
      wake_req <= 1'b1;
      @(posedge sys_clk);
      wake_req <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk("cpu_run woken", 32'h1, {31'h0, cpu_run});
   endtask
   task automatic t_slow();
      int n;
      wr(ADDR_FOC, 8'h00);
      wr(ADDR_SCC, 8'he0);
      n = 0;
      while (op_mode !== SCMC_SLOW && n < 3000) begin
         @(posedge sys_clk);
         n++;
      end
      chk("op_mode slow", 32'(SCMC_SLOW), 32'(op_mode));
      repeat (5) @(posedge sys_clk);
      chk("fast off in slow", 32'h0, {31'h0, fast_osc_on});
      rd(ADDR_FOC, 32'h0000_0000, RESP_OKAY);
      wr(ADDR_FOC, 8'h01);
      repeat (5) @(posedge sys_clk);
      chk("fast on in slow", 32'h1, {31'h0, fast_osc_on});
      rd(ADDR_FOC, 32'h0000_0001, RESP_OKAY);
      repeat (410) @(posedge sys_clk);
      rd(ADDR_FOC, 32'h0000_0003, RESP_OKAY);
   endtask
   task automatic give_verdict();
      if (mismatches == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      give_verdict();
   end
   initial begin
      sys_clk = 1'b0;
      reset = 1'b1;
      axi_req = '0;
      halt_req = 1'b0;
      wake_req = 1'b0;
      wdt_enable = 1'b0;
      repeat (6) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      t_regs();
      t_irq();
      t_halt(1'b0, 1'b0, 1'b0, SCMC_SLEEP);
      t_halt(1'b0, 1'b0, 1'b1, SCMC_SLEEP);
      t_halt(1'b0, 1'b1, 1'b0, SCMC_IDLE_SUB_ONLY);
      t_halt(1'b1, 1'b1, 1'b0, SCMC_IDLE_BOTH_ON);
      t_halt(1'b1, 1'b0, 1'b0, SCMC_IDLE_FAST_ONLY);
      repeat (450) @(posedge sys_clk);
      t_slow();
      give_verdict();
   end
endmodule // tb_top
